// ### dcm_map.svh
`ifndef DCM_MAP_SVH
`define DCM_MAP_SVH

// command codes on {ras_n, cas_n, we_n} with cs_n low
`define DCM_CMD_MRS 3'h0
`define DCM_CMD_WR 3'h4
`define DCM_CMD_RD 3'h5

// bank address of a mode register set command
`define DCM_MR_ZERO 3'h0
`define DCM_MR_ONE 3'h1
`define DCM_MR_THREE 3'h3

// address bit positions
`define DCM_WL_BIT 7
`define DCM_PATTERN_EN_BIT 2
`define DCM_NIBBLE_BIT 2
`define DCM_AUTOPRE_BIT 10
`define DCM_BC_PIN_BIT 12
`define DCM_LOC_LSB 0
`define DCM_LOC_MSB 1
`define DCM_BL_LSB 0
`define DCM_BL_MSB 1

// burst length field of mode register zero
`define DCM_BL_FIXED8 2'h0
`define DCM_BL_OTF 2'h1
`define DCM_BL_FIXED4 2'h2

// pattern locations and contents, beat 0 in the lsb
`define DCM_LOC_PATTERN 2'h0
`define DCM_PATTERN_BYTE 8'hAA
`define DCM_RSVD_BYTE 8'h00

// beats per burst and nibble start
`define DCM_BEATS_EIGHT 4'h8
`define DCM_BEATS_FOUR 4'h4
`define DCM_NIBBLE_LOW 3'h0
`define DCM_NIBBLE_HIGH 3'h4

// reset value of a mode register
`define DCM_MR_RESET 15'h0000

`endif

// ### dcm_pkg.sv
package dcm_pkg;

   typedef enum logic {
      DCM_IDLE,
      DCM_BURST
   } dcm_burst_t;

endpackage : dcm_pkg

// ### dcm_sync2.sv
`timescale 1ns/1ps
module dcm_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] stage_one;
      logic [W-1:0] stage_two;
   } dcm_sync_t;

   dcm_sync_t st_r;
   dcm_sync_t st_nxt;

   // the first stage feeds only the second
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.stage_one = async_in;
      st_nxt.stage_two = st_r.stage_one;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.stage_two;

endmodule : dcm_sync2

// ### dcm_calib.sv
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "dcm_map.svh"
module dcm_calib #(
   parameter int MAX_RL = 32,
   parameter int TMOD_CK = 12,
   parameter bit DQ_COPY_ALL = 1'b1
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ck,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [14:0] addr,
   input wire logic odt,
   input wire logic reset_n,
   input wire logic [4:0] cas_latency,
   input wire logic [4:0] additive_latency,
   output logic [7:0] dq_o,
   output logic dq_oe,
   output logic dqs_o,
   output logic dqs_oe,
   output logic dqs_term_on,
   output logic wl_mode,
   output logic pattern_mode,
   output logic array_rd,
   output logic array_wr,
   output logic array_autopre
);

   localparam int QW = $clog2(MAX_RL);
   localparam int TW = $clog2(TMOD_CK + 1);
   localparam int SW = 25;
   localparam logic [TW-1:0] TMOD_LOAD = TW'(TMOD_CK);

   typedef struct packed {
      logic ck_prev;
      logic [14:0] mode_register_zero;
      logic [14:0] mode_register_one;
      logic [14:0] mode_register_three;
      // latency line: one slot per ck, slot 0 fires at the next rise
      logic [MAX_RL-1:0] q_vld;
      logic [MAX_RL-1:0] q_bc4;
      logic [MAX_RL-1:0] q_upper;
      dcm_pkg::dcm_burst_t burst;
      logic [2:0] beat_idx;
      logic [3:0] beats_left;
      logic [7:0] pat;
      logic [TW-1:0] tmod_cnt;
      logic [7:0] dq;
      logic dq_oe;
      logic dqs;
      logic dqs_oe;
      logic term_on;
      logic rd;
      logic wr;
      logic ap;
   } dcm_state_t;

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic [QW-1:0] rl_slot(input logic [4:0] al, input logic [4:0] cl);
      logic [5:0] rl;
      rl = {1'b0, al} + {1'b0, cl};
      // out-of-range settings clamp rather than wrap around the line
      if (rl == 6'h00)
      begin
         rl_slot = '0;
      end
      else if (rl > 6'(MAX_RL))
      begin
         rl_slot = QW'(MAX_RL - 1);
      end
      else
      begin
         rl_slot = QW'(rl - 6'h01);
      end
   endfunction : rl_slot

   function automatic logic [7:0] loc_byte(input logic [1:0] loc);
      if (loc == `DCM_LOC_PATTERN)
      begin
         loc_byte = `DCM_PATTERN_BYTE;
      end
      else
      begin
         loc_byte = `DCM_RSVD_BYTE;
      end
   endfunction : loc_byte

   function automatic logic [7:0] beat_out(input logic [7:0] pat, input logic [2:0] idx);
      logic b;
      b = pat[idx];
      beat_out = {{7{b & DQ_COPY_ALL}}, b};
   endfunction : beat_out

   // shared decode: selected, and the three command pins match
   function automatic logic cmd_hit(input logic sel_n, input logic [2:0] pins,
      input logic [2:0] code);
      cmd_hit = ~sel_n & (pins == code);
   endfunction : cmd_hit

   ////////////////////////////////////////////////////////////////////////////

   logic [SW-1:0] pins_s;
   logic ck_s;
   logic cs_n_s;
   logic ras_n_s;
   logic cas_n_s;
   logic we_n_s;
   logic [2:0] ba_s;
   logic [14:0] addr_s;
   logic odt_s;
   logic reset_n_s;

   // pins and ck share one synchroniser, so a command stays aligned with its edge
   dcm_sync2 #(
      .W(SW)
   ) u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .async_in({ck, cs_n, ras_n, cas_n, we_n, ba, addr, odt, reset_n}),
      .sync_out(pins_s)
   );

   assign {ck_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, odt_s, reset_n_s} = pins_s;

   ////////////////////////////////////////////////////////////////////////////

   dcm_state_t st_r;
   dcm_state_t st_nxt;

   logic rise;
   logic fall;
   logic [2:0] cmd;
   logic is_mrs;
   logic is_rd;
   logic is_wr;
   logic pat_en;
   logic chop;
   logic start;
   logic [QW-1:0] slot;

   assign rise = ck_s & ~st_r.ck_prev;
   assign fall = ~ck_s & st_r.ck_prev;
   assign cmd = {ras_n_s, cas_n_s, we_n_s};
   assign is_mrs = rise & cmd_hit(cs_n_s, cmd, `DCM_CMD_MRS);
   assign is_rd = rise & cmd_hit(cs_n_s, cmd, `DCM_CMD_RD);
   assign is_wr = rise & cmd_hit(cs_n_s, cmd, `DCM_CMD_WR);
   assign pat_en = st_r.mode_register_three[`DCM_PATTERN_EN_BIT];
   // latency is static configuration, so it is read unsynchronised
   assign slot = rl_slot(additive_latency, cas_latency);
   assign start = rise & st_r.q_vld[0];

   // chop decided at read time from the pin only when on-the-fly is set
   always_comb
   begin
      unique case (st_r.mode_register_zero[`DCM_BL_MSB:`DCM_BL_LSB])
         `DCM_BL_FIXED4: chop = 1'b1;
         `DCM_BL_OTF: chop = ~addr_s[`DCM_BC_PIN_BIT];
         default: chop = 1'b0;
      endcase
   end

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.ck_prev = ck_s;
      st_nxt.rd = 1'b0;
      st_nxt.wr = 1'b0;
      st_nxt.ap = 1'b0;

      // mode register loads
      if (is_mrs)
      begin
         unique case (ba_s)
            `DCM_MR_ZERO: st_nxt.mode_register_zero = addr_s;
            `DCM_MR_ONE:
            begin
               st_nxt.mode_register_one = addr_s;
               // only a real exit starts the tail; a repeated clear does not
               if (st_r.mode_register_one[`DCM_WL_BIT] && !addr_s[`DCM_WL_BIT])
               begin
                  st_nxt.tmod_cnt = TMOD_LOAD;
               end
            end
            `DCM_MR_THREE: st_nxt.mode_register_three = addr_s;
            default:
            begin
            end
         endcase
      end
      else if (rise && st_r.tmod_cnt != '0)
      begin
         st_nxt.tmod_cnt = st_r.tmod_cnt - TW'(1);
      end

      // latency line advances one slot per command clock rise
      if (rise)
      begin
         st_nxt.q_vld = st_r.q_vld >> 1;
         st_nxt.q_bc4 = st_r.q_bc4 >> 1;
         st_nxt.q_upper = st_r.q_upper >> 1;
      end

      if (is_rd && pat_en)
      begin
         // autoprecharge ignored here on purpose; banks are idle anyway
         st_nxt.q_vld[slot] = 1'b1;
         st_nxt.q_bc4[slot] = chop;
         st_nxt.q_upper[slot] = chop & addr_s[`DCM_NIBBLE_BIT];
      end
      else if (is_rd)
      begin
         st_nxt.rd = 1'b1;
         st_nxt.ap = addr_s[`DCM_AUTOPRE_BIT];
      end
      else if (is_wr && !pat_en)
      begin
         // writes in pattern mode are illegal and dropped
         st_nxt.wr = 1'b1;
         st_nxt.ap = addr_s[`DCM_AUTOPRE_BIT];
      end

      // beat engine, one beat per command clock edge
      unique case (st_r.burst)
         dcm_pkg::DCM_IDLE:
         begin
            st_nxt.dqs_oe = 1'b0;
            st_nxt.dqs = 1'b0;
         end
         dcm_pkg::DCM_BURST:
         begin
            if ((rise || fall) && st_r.beats_left != 4'h0)
            begin
               st_nxt.dq = beat_out(st_r.pat, st_r.beat_idx);
               st_nxt.dqs = rise;
               st_nxt.beat_idx = st_r.beat_idx + 3'h1;
               st_nxt.beats_left = st_r.beats_left - 4'h1;
            end
            // the edge after the last beat releases the strobe
            else if (rise || fall)
            begin
               st_nxt.burst = dcm_pkg::DCM_IDLE;
               st_nxt.dqs_oe = 1'b0;
               st_nxt.dqs = 1'b0;
            end
         end
      endcase

      // a new burst may butt against the previous one
      if (start)
      begin
         st_nxt.burst = dcm_pkg::DCM_BURST;
         st_nxt.pat = loc_byte(st_r.mode_register_three[`DCM_LOC_MSB:`DCM_LOC_LSB]);
         st_nxt.beat_idx = st_r.q_upper[0] ? `DCM_NIBBLE_HIGH : `DCM_NIBBLE_LOW;
         st_nxt.dq = beat_out(st_nxt.pat, st_nxt.beat_idx);
         st_nxt.beat_idx = st_nxt.beat_idx + 3'h1;
         st_nxt.beats_left = (st_r.q_bc4[0] ? `DCM_BEATS_FOUR : `DCM_BEATS_EIGHT) - 4'h1;
         // the first beat leaves on a rise, so the strobe opens high
         st_nxt.dqs = 1'b1;
         st_nxt.dqs_oe = 1'b1;
      end

      // leveling and its tail hold the data pins driven, at zero outside a burst
      if (st_nxt.mode_register_one[`DCM_WL_BIT] || st_nxt.tmod_cnt != '0)
      begin
         st_nxt.dq_oe = 1'b1;
         if (st_nxt.burst == dcm_pkg::DCM_IDLE)
         begin
            st_nxt.dq = 8'h00;
         end
      end
      else
      begin
         st_nxt.dq_oe = (st_nxt.burst == dcm_pkg::DCM_BURST);
         if (st_nxt.burst == dcm_pkg::DCM_IDLE)
         begin
            st_nxt.dq = 8'h00;
         end
      end

      // in leveling only the strobe termination follows the pin
      st_nxt.term_on = st_nxt.mode_register_one[`DCM_WL_BIT] & odt_s;
   end

   ////////////////////////////////////////////////////////////////////////////

   // device reset pin clears everything but ck_prev, which loads high; pattern mode included
   always_ff @(posedge clk_sys)
   begin
      if (srst || !reset_n_s)
      begin
         st_r <= '0;
         st_r.ck_prev <= 1'b1;
         st_r.mode_register_zero <= `DCM_MR_RESET;
         st_r.mode_register_one <= `DCM_MR_RESET;
         st_r.mode_register_three <= `DCM_MR_RESET;
         st_r.burst <= dcm_pkg::DCM_IDLE;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign dq_o = st_r.dq;
   assign dq_oe = st_r.dq_oe;
   assign dqs_o = st_r.dqs;
   assign dqs_oe = st_r.dqs_oe;
   assign dqs_term_on = st_r.term_on;
   assign wl_mode = st_r.mode_register_one[`DCM_WL_BIT];
   assign pattern_mode = pat_en;
   assign array_rd = st_r.rd;
   assign array_wr = st_r.wr;
   assign array_autopre = st_r.ap;

endmodule : dcm_calib

// ### dcm_calib_chk.sv
`timescale 1ns/1ps
module dcm_calib_chk #(
   parameter bit DQ_COPY_ALL = 1'b1
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [7:0] dq_o,
   input wire logic dq_oe,
   input wire logic dqs_o,
   input wire logic dqs_oe,
   input wire logic dqs_term_on,
   input wire logic wl_mode,
   input wire logic pattern_mode,
   input wire logic array_rd,
   input wire logic array_wr,
   input wire logic array_autopre
);
   logic [4:0] beat_r;
   logic dqs_r;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   ////////////////////
   // seamless bursts keep the enable up, so only whole bursts are counted
   always_ff @(posedge clk_sys)
   begin
      dqs_r <= dqs_o;
      if (srst || !dqs_oe)
         beat_r <= 5'h00;
      else if (beat_r == 5'h00 || dqs_o != dqs_r)
         beat_r <= beat_r + 5'h01;
   end
   ////////////////////
   a_term_needs_wl: assert property (dqs_term_on |-> wl_mode)
      else $error("termination outside leveling");
   a_wl_quiet: assert property (wl_mode |-> !dqs_oe && dq_o == 8'h00)
      else $error("strobe or data in leveling");
   a_pattern_no_array: assert property (pattern_mode |-> !array_rd && !array_wr)
      else $error("array access in pattern mode");
   a_autopre_read: assert property (array_autopre |-> (array_rd || array_wr) && !pattern_mode)
      else $error("autoprecharge without array access");
   a_copy_lines: assert property (dq_oe && !wl_mode |->
      dq_o[7:1] == (DQ_COPY_ALL ? {7{dq_o[0]}} : 7'h00)) else $error("data lines differ");
   a_burst_beats: assert property ($fell(dqs_oe) |-> beat_r[1:0] == 2'h0 && beat_r != 5'h00)
      else $error("burst not whole");
   a_first_beat: assert property ($rose(dqs_oe) |-> dqs_o && dq_oe)
      else $error("burst starts on wrong edge");
   a_reset_clear: assert property ($fell(srst) |-> !pattern_mode && !wl_mode && !dqs_oe)
      else $error("modes not cleared");
   c_pattern_on: cover property ($rose(pattern_mode));
   c_burst_end: cover property ($fell(dqs_oe));
   c_wl_exit: cover property ($fell(wl_mode));
endmodule : dcm_calib_chk

bind dcm_calib dcm_calib_chk #(.DQ_COPY_ALL(DQ_COPY_ALL)) dcm_calib_chk_inst (
   .clk_sys(clk_sys), .srst(srst), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o),
   .dqs_oe(dqs_oe), .dqs_term_on(dqs_term_on), .wl_mode(wl_mode),
   .pattern_mode(pattern_mode), .array_rd(array_rd), .array_wr(array_wr),
   .array_autopre(array_autopre));

// ### dcm_ctl_model.sv
`timescale 1ns/1ps
module dcm_ctl_model (
   input wire logic clk_sys,
   output logic ck,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] ba,
   output logic [14:0] addr
);
   logic [1:0] cnt_r = 2'h0;
   // no strobes driven here, so none runs into a leveling exit
   initial
   begin
      ck = 1'b0;
      {cs_n, ras_n, cas_n, we_n, ba, addr} = {4'hF, 18'h00000};
   end
   always @(posedge clk_sys)
   begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == 2'h3)
         ck <= ~ck;
   end
   ////////////////////
   // pins change with the falling clock and stand through the next rise
   task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [14:0] a,
      input int gap);
      do
         @(posedge clk_sys);
      while (!(ck && cnt_r == 2'h3));
      cs_n <= 1'b0;
      {ras_n, cas_n, we_n} <= c;
      ba <= b;
      addr <= a;
      repeat (8)
         @(posedge clk_sys);
      // released pins must not keep a stale value
      cs_n <= 1'b1;
      ba <= ~b;
      addr <= ~a;
      repeat (8 * gap)
         @(posedge clk_sys);
   endtask : cmd
endmodule : dcm_ctl_model

// ### dcm_calib_bench.sv
`timescale 1ns/1ps
`include "dcm_map.svh"
module dcm_calib_bench;
   typedef struct packed {
      logic [1:0] loc;
      logic a2;
      logic a12;
      logic ap;
      logic [7:0] exp;
      logic [3:0] beats;
   } dcm_row_t;
   // additive 1 plus CAS 3 ck of eight clk each, counted from the command's return
   localparam logic [7:0] RL_CLK = 8'h20;
   // chop rows need mode register zero on-the-fly
   localparam dcm_row_t ROWS [5] = '{
      '{2'h0, 1'b0, 1'b1, 1'b0, 8'hAA, 4'h8},
      '{2'h0, 1'b0, 1'b0, 1'b1, 8'h0A, 4'h4},
      '{2'h0, 1'b1, 1'b0, 1'b0, 8'h0A, 4'h4},
      '{2'h1, 1'b0, 1'b1, 1'b1, 8'h00, 4'h8},
      '{2'h3, 1'b1, 1'b0, 1'b0, 8'h00, 4'h4}};
   logic clk_sys, srst, reset_n, odt, ck, cs_n, ras_n, cas_n, we_n, ok;
   logic dq_oe, dqs_o, dqs_oe, dqs_term_on, wl_mode, pattern_mode;
   logic array_rd, array_wr, array_autopre;
   logic [2:0] ba;
   logic [14:0] addr;
   logic [7:0] dq_o, bits, lat;
   logic [7:0] rd_cnt = 8'h00, wr_cnt = 8'h00, ap_cnt = 8'h00;
   logic [3:0] n;
   int fail_count = 0, tests_run = 0, w;

   dcm_ctl_model ctl_inst (.clk_sys(clk_sys), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
   dcm_calib #(.TMOD_CK(2)) dcm_calib_inst (.clk_sys(clk_sys), .srst(srst), .ck(ck),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
      .odt(odt), .reset_n(reset_n), .cas_latency(5'h03), .additive_latency(5'h01),
      .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dqs_term_on(dqs_term_on),
      .wl_mode(wl_mode), .pattern_mode(pattern_mode), .array_rd(array_rd),
      .array_wr(array_wr), .array_autopre(array_autopre));
   ////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever
         #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      rd_cnt <= rd_cnt + {7'h00, array_rd};
      wr_cnt <= wr_cnt + {7'h00, array_wr};
      ap_cnt <= ap_cnt + {7'h00, array_autopre};
   end
   ////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic tmo(input int lim);
      if (w >= lim)
      begin
         fail_count++;
         test_done();
      end
   endtask : tmo
   // one beat per strobe level, read until the strobe is released
   task automatic grab();
      logic prev;
      {bits, n, ok, w} = {8'h00, 4'h0, 1'b1, 32'd0};
      while (dqs_oe !== 1'b1 && w < 300)
      begin
         @(posedge clk_sys);
         w++;
      end
      lat = 8'(w);
      while (dqs_oe === 1'b1 && w < 600)
      begin
         bits[n[2:0]] = dq_o[0];
         ok = ok & (dq_o[7:1] === {7{dq_o[0]}});
         n++;
         prev = dqs_o;
         while (dqs_o === prev && dqs_oe === 1'b1 && w < 600)
         begin
            @(posedge clk_sys);
            w++;
         end
      end
      tmo(300);
   endtask : grab
   ////////////////////
   initial
   begin
      {srst, reset_n, odt} = 3'b110;
      repeat (6)
         @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      chk("reset", 8'h00, {wl_mode, pattern_mode, dq_oe, dqs_oe, dqs_term_on, array_rd,
         array_wr, array_autopre});
      $display("reset check done");
      ctl_inst.cmd(`DCM_CMD_MRS, `DCM_MR_ZERO, {13'h0000, `DCM_BL_OTF}, 1);
      foreach (ROWS[i])
      begin
         ctl_inst.cmd(`DCM_CMD_MRS, `DCM_MR_THREE, {12'h000, 1'b1, ROWS[i].loc}, 3);
         chk("mode", 8'h01, {7'h00, pattern_mode});
         ctl_inst.cmd(`DCM_CMD_RD, 3'h5, {2'h0, ROWS[i].a12, 1'b0, ROWS[i].ap, 7'h7F,
            ROWS[i].a2, 2'h0}, 0);
         grab();
         chk("latency", RL_CLK, lat);
         chk("bits", ROWS[i].exp, bits);
         chk("beats copy", {3'h0, 1'b1, ROWS[i].beats}, {3'h0, ok, n});
         $display("row %0d done", i);
      end
      chk("array in pattern", 8'h00, rd_cnt | ap_cnt);
      ctl_inst.cmd(`DCM_CMD_MRS, `DCM_MR_THREE, 15'h0003, 3);
      chk("mode off", 8'h00, {7'h00, pattern_mode});
      ctl_inst.cmd(`DCM_CMD_RD, 3'h0, 15'h0400, 1);
      ctl_inst.cmd(`DCM_CMD_WR, 3'h0, 15'h0000, 1);
      chk("array rd ap wr", 8'h15, {2'h0, rd_cnt[1:0], ap_cnt[1:0], wr_cnt[1:0]});
      $display("normal done");
      // fixed burst settings override the chop pin either way
      for (int k = 0; k < 2; k++)
      begin
         ctl_inst.cmd(`DCM_CMD_MRS, `DCM_MR_ZERO,
            {13'h0000, (k == 0) ? `DCM_BL_FIXED4 : `DCM_BL_FIXED8}, 1);
         ctl_inst.cmd(`DCM_CMD_MRS, `DCM_MR_THREE, 15'h0004, 3);
         ctl_inst.cmd(`DCM_CMD_RD, 3'h0, {2'h0, (k == 0), 12'h000}, 0);
         grab();
         chk("fixed bits", (k == 0) ? 8'h0A : 8'hAA, bits);
         chk("fixed beats", (k == 0) ? 8'h04 : 8'h08, {4'h0, n});
         ctl_inst.cmd(`DCM_CMD_MRS, `DCM_MR_THREE, 15'h0000, 3);
      end
      $display("fixed burst done");
      ctl_inst.cmd(`DCM_CMD_MRS, `DCM_MR_ONE, 15'h0080, 3);
      chk("wl on", 8'h03, {6'h00, wl_mode, dq_oe});
      odt <= 1'b1;
      repeat (6)
         @(posedge clk_sys);
      chk("term on", 8'h01, {7'h00, dqs_term_on});
      odt <= 1'b0;
      repeat (6)
         @(posedge clk_sys);
      chk("term off", 8'h00, {7'h00, dqs_term_on});
      ctl_inst.cmd(`DCM_CMD_MRS, `DCM_MR_ONE, 15'h0000, 0);
      w = 0;
      while (wl_mode !== 1'b0 && w < 40)
      begin
         @(posedge clk_sys);
         w++;
      end
      tmo(40);
      chk("dq held", 8'h01, {7'h00, dq_oe});
      repeat (24)
         @(posedge clk_sys);
      chk("dq released", 8'h00, {7'h00, dq_oe});
      $display("leveling done");
      ctl_inst.cmd(`DCM_CMD_MRS, `DCM_MR_THREE, 15'h0004, 3);
      reset_n <= 1'b0;
      repeat (5)
         @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (5)
         @(posedge clk_sys);
      chk("device reset", 8'h00, {7'h00, pattern_mode});
      $display("reset done");
      test_done();
   end
endmodule : dcm_calib_bench
